// [mmls_defines.vh]
// Constants for the memory move and load/store execution block.
`ifndef MMLS_DEFINES_VH
`define MMLS_DEFINES_VH

// Register indices; the byte address on the bus is four times the index.
`define MMLS_IDX_DMA_MODE_REGISTER    5'h00
`define MMLS_IDX_DCTRL    5'h01
`define MMLS_IDX_DSBASE   5'h02
`define MMLS_IDX_FBR      5'h03
`define MMLS_IDX_IPTR     5'h04
`define MMLS_IDX_STATUS   5'h05
`define MMLS_IDX_REGBASE  5'h06
`define MMLS_IDX_SCRATCH  5'h07
`define MMLS_IDX_BCOUNT   5'h08
`define MMLS_IDX_OPERAND  5'h09
`define MMLS_IDX_CSAVE    5'h0a

// Field positions.
`define MMLS_DMA_MODE_REGISTER_SRC_IO   5
`define MMLS_DMA_MODE_REGISTER_DST_IO   4
`define MMLS_DCTRL_PF_EN    1
`define MMLS_ST_ILLEGAL     0
`define MMLS_ST_HALTED      8
`define MMLS_ST_BUSY        9
`define MMLS_W0_MOVE_NOFL   24
`define MMLS_W0_LS_REL      28
`define MMLS_W0_LS_NOFL     25
`define MMLS_W0_LS_LOAD     24
`define MMLS_W0_TC_IFTRUE   19
`define MMLS_W0_TC_CMPDATA  18

// Instruction types in bits 31 to 29 of the first word.
`define MMLS_OP_TC        3'h4
`define MMLS_OP_MOVE      3'h6
`define MMLS_OP_LS        3'h7

// Illegal instruction cause codes.
`define MMLS_CAUSE_RSVD   4'h1
`define MMLS_CAUSE_ALIGN  4'h2
`define MMLS_CAUSE_COUNT  4'h3
`define MMLS_CAUSE_SELF   4'h4
`define MMLS_CAUSE_OPC    4'h5

// Reset values and sizes.
`define MMLS_RST_WORD     32'h00000000
`define MMLS_RST_REGBASE  32'hffffff80
`define MMLS_JUMP_STEP    32'h00000004
`define MMLS_FIFO_DEPTH   3'h4

`endif

// [mmls_exec.v]
// Memory move, load/store and jump-target execution unit with an APB register file.
//
// Behaviour
// - Set compare-mask bits make the matching first_byte_received bits be ignored.
// - Compare value is checked against first_byte_received, qualified by the mask.
// - Taken jump fetches from the second word; pointer becomes that address plus four.
// - Two DMA mode bits pick memory or I/O space for source and destination.
// - Move byte count is the low 24 bits of the first word.
// - Differing low address bits of move source and destination are illegal.
// - Move bursts source data into the DMA FIFO, writes it out, until count is zero.
// - Any set reserved bit 28 to 25 of a move is illegal.
// - Move flushes prefetch unless no-flush is set with prefetch enabled.
// - Move address in own register window uses the register chosen by seven bits.
// - first_byte_received is never written by host or by moves.
// - Move source is the second word, destination the third held in call-save.
// - Load/store moves one to four bytes and never crosses a word boundary.
// - Load/store hitting own registers still runs the bus cycle, moves nothing, is illegal.
// - Load source and store target use I/O commands when their space bit is set.
// - Type 111 in bits 31 to 29 is a load/store.
// - Bit 28 clear uses absolute address, set adds signed 24-bit offset to base.
// - Store flushes prefetch unless bit 25 set with prefetch enabled; loads never flush.
// - Bit 24 set means load, clear means store.
// - Register address is bits 22 to 16, byte count bits 2 to 0.
// - Loads into first_byte_received are dropped; stores of it work.
// - data_structure_base keeps its value across a memory move; here a move whose destination is its own-window register still writes it.
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "mmls_defines.vh"

module mmls_exec (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        rst,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Instruction words from the fetch unit
  input  wire        instr_valid,
  input  wire [31:0] instr_w0,
  input  wire [31:0] instr_w1,
  input  wire [31:0] instr_w2,
  output wire        instr_ready,
  // Script register write path into first_byte_received
  input  wire        fbr_load,
  input  wire [7:0]  fbr_data,
  // Bus master toward system memory and I/O
  output wire        bm_req,
  output wire        bm_we,
  output wire        bm_io,
  output wire [31:0] bm_addr,
  output wire [31:0] bm_wdata,
  output wire [3:0]  bm_be,
  input  wire        bm_ack,
  input  wire [31:0] bm_rdata,
  // Sequencer events
  output wire        exec_done,
  output wire        jump_taken,
  output wire [31:0] jump_addr,
  output wire        prefetch_flush,
  output wire        illegal_instr
);

  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_DEC  = 3'h1;
  localparam [2:0] S_MRD  = 3'h2;
  localparam [2:0] S_MWR  = 3'h3;
  localparam [2:0] S_LS   = 3'h4;
  localparam [2:0] S_DONE = 3'h5;

  // Software visible registers
  reg [31:0] dma_mode_register_r;
  reg [31:0] dctrl_r;
  reg [31:0] dsbase_r;
  reg [7:0]  fbr_r;
  reg [31:0] iptr_r;
  reg        ill_r;
  reg [3:0]  cause_r;
  reg        halt_r;
  reg [31:0] regbase_r;
  reg [31:0] scratch_r;
  reg [23:0] bcount_r;
  reg [31:0] operand_r;
  reg [31:0] csave_r;
  // Execution state
  reg [2:0]  state_r;
  reg [31:0] w0_r;
  reg [23:0] rleft_r;
  reg [31:0] fifo_d_r [0:3];
  reg [3:0]  fifo_b_r [0:3];
  reg [1:0]  rptr_r;
  reg [1:0]  wptr_r;
  reg [2:0]  fcnt_r;
  // Output flops
  reg [31:0] prdata_r;
  reg        pready_r;
  reg        pslverr_r;
  reg        ready_r;
  reg        bm_req_r;
  reg        bm_we_r;
  reg        bm_io_r;
  reg [31:0] bm_addr_r;
  reg [31:0] bm_wdata_r;
  reg [3:0]  bm_be_r;
  reg        done_r;
  reg        jump_r;
  reg [31:0] jaddr_r;
  reg        flush_r;

  assign prdata         = prdata_r;
  assign pready         = pready_r;
  assign pslverr        = pslverr_r;
  assign instr_ready    = ready_r;
  assign bm_req         = bm_req_r;
  assign bm_we          = bm_we_r;
  assign bm_io          = bm_io_r;
  assign bm_addr        = bm_addr_r;
  assign bm_wdata       = bm_wdata_r;
  assign bm_be          = bm_be_r;
  assign exec_done      = done_r;
  assign jump_taken     = jump_r;
  assign jump_addr      = jaddr_r;
  assign prefetch_flush = flush_r;
  assign illegal_instr  = ill_r;

  function [31:0] rd_word;
    input [4:0] idx;
    begin
      case (idx)
        `MMLS_IDX_DMA_MODE_REGISTER:   rd_word = dma_mode_register_r;
        `MMLS_IDX_DCTRL:   rd_word = dctrl_r;
        `MMLS_IDX_DSBASE:  rd_word = dsbase_r;
        `MMLS_IDX_FBR:     rd_word = {24'h000000, fbr_r};
        `MMLS_IDX_IPTR:    rd_word = iptr_r;
        `MMLS_IDX_STATUS:  rd_word = {22'h000000, state_r != S_IDLE, halt_r, 3'h0, cause_r, ill_r};
        `MMLS_IDX_REGBASE: rd_word = regbase_r;
        `MMLS_IDX_SCRATCH: rd_word = scratch_r;
        `MMLS_IDX_BCOUNT:  rd_word = {8'h00, bcount_r};
        `MMLS_IDX_OPERAND: rd_word = operand_r;
        `MMLS_IDX_CSAVE:   rd_word = csave_r;
        default:           rd_word = 32'h00000000;
      endcase
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  be;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1)
        merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  // Lanes for n bytes starting at byte offset off inside one word.
  function [3:0] lanes;
    input [1:0] off;
    input [2:0] n;
    reg [7:0] t;
    begin
      t = (8'h01 << n) - 8'h01;
      t = t << off;
      lanes = t[3:0];
    end
  endfunction

  // Bytes of one beat: up to the word boundary, never more than are left.
  function [2:0] beat_n;
    input [1:0]  off;
    input [23:0] left;
    reg [2:0] room;
    begin
      room = 3'h4 - {1'b0, off};
      beat_n = (left < {21'h000000, room}) ? left[2:0] : room;
    end
  endfunction

  function [2:0] pop4;
    input [3:0] b;
    begin
      pop4 = {2'h0, b[0]} + {2'h0, b[1]} + {2'h0, b[2]} + {2'h0, b[3]};
    end
  endfunction

  function own_hit;
    input [31:0] a;
    begin
      own_hit = (a[31:7] == regbase_r[31:7]);
    end
  endfunction

  // Internal register write from a move or a load; first_byte_received is not in the list.
  task wr_word;
    input [4:0]  idx;
    input [31:0] d;
    input [3:0]  be;
    begin
      case (idx)
        `MMLS_IDX_DMA_MODE_REGISTER:   dma_mode_register_r <= merge(dma_mode_register_r, d, be);
        `MMLS_IDX_DCTRL:   dctrl_r <= merge(dctrl_r, d, be);
        `MMLS_IDX_DSBASE:  dsbase_r <= merge(dsbase_r, d, be);
        `MMLS_IDX_SCRATCH: scratch_r <= merge(scratch_r, d, be);
        default:           dma_mode_register_r <= dma_mode_register_r;
      endcase
    end
  endtask

  wire [2:0]  op       = w0_r[31:29];
  wire        pf_en    = dctrl_r[`MMLS_DCTRL_PF_EN];
  wire [31:0] ls_addr  = w0_r[`MMLS_W0_LS_REL] ? dsbase_r + {{8{operand_r[23]}}, operand_r[23:0]}
                                                : operand_r;
  wire [4:0]  ls_idx   = w0_r[22:18];
  wire [1:0]  ls_roff  = w0_r[17:16];
  wire [2:0]  ls_cnt   = w0_r[2:0];
  wire        ls_load  = w0_r[`MMLS_W0_LS_LOAD];
  wire        cmp_ok   = ((fbr_r ^ w0_r[7:0]) & ~w0_r[15:8]) == 8'h00;
  wire        tc_take  = ~w0_r[`MMLS_W0_TC_CMPDATA] | (cmp_ok == w0_r[`MMLS_W0_TC_IFTRUE]);
  wire [2:0]  rn       = beat_n(operand_r[1:0], rleft_r);
  wire [3:0]  rbe      = lanes(operand_r[1:0], rn);
  wire [3:0]  ls_be    = lanes(ls_addr[1:0], ls_cnt);
  wire        ls_bad   = (ls_cnt == 3'h0) || ({2'h0, ls_addr[1:0]} + {1'b0, ls_cnt} > 4'h4)
                         || (ls_addr[1:0] != ls_roff);
  wire        apb_go   = psel & penable & ~pready_r;
  wire        apb_wr   = psel & penable & pready_r & pwrite;
  wire        accept   = instr_valid & ready_r;

  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      dma_mode_register_r    <= `MMLS_RST_WORD;
      dctrl_r    <= `MMLS_RST_WORD;
      dsbase_r   <= `MMLS_RST_WORD;
      fbr_r      <= 8'h00;
      iptr_r     <= `MMLS_RST_WORD;
      ill_r      <= 1'b0;
      cause_r    <= 4'h0;
      halt_r     <= 1'b0;
      regbase_r  <= `MMLS_RST_REGBASE;
      scratch_r  <= `MMLS_RST_WORD;
      bcount_r   <= 24'h000000;
      operand_r  <= `MMLS_RST_WORD;
      csave_r    <= `MMLS_RST_WORD;
      state_r    <= S_IDLE;
      w0_r       <= `MMLS_RST_WORD;
      rleft_r    <= 24'h000000;
      rptr_r     <= 2'h0;
      wptr_r     <= 2'h0;
      fcnt_r     <= 3'h0;
      prdata_r   <= `MMLS_RST_WORD;
      pready_r   <= 1'b0;
      pslverr_r  <= 1'b0;
      ready_r    <= 1'b0;
      bm_req_r   <= 1'b0;
      bm_we_r    <= 1'b0;
      bm_io_r    <= 1'b0;
      bm_addr_r  <= `MMLS_RST_WORD;
      bm_wdata_r <= `MMLS_RST_WORD;
      bm_be_r    <= 4'h0;
      done_r     <= 1'b0;
      jump_r     <= 1'b0;
      jaddr_r    <= `MMLS_RST_WORD;
      flush_r    <= 1'b0;
    end
    else
    begin
      done_r  <= 1'b0;
      jump_r  <= 1'b0;
      flush_r <= 1'b0;
      // APB: one wait state, then the answer; writes land on the pready edge.
      pready_r <= apb_go;
      if (apb_go)
      begin
        prdata_r  <= rd_word(paddr[6:2]);
        pslverr_r <= (paddr[7] | (paddr[6:2] > `MMLS_IDX_CSAVE));
      end
      if (apb_wr && !paddr[7])
      begin
        case (paddr[6:2])
          `MMLS_IDX_DMA_MODE_REGISTER:   dma_mode_register_r <= pwdata;
          `MMLS_IDX_DCTRL:   dctrl_r <= pwdata;
          `MMLS_IDX_DSBASE:  dsbase_r <= pwdata;
          `MMLS_IDX_IPTR:    iptr_r <= pwdata;
          `MMLS_IDX_REGBASE: regbase_r <= pwdata;
          `MMLS_IDX_SCRATCH: scratch_r <= pwdata;
          `MMLS_IDX_STATUS:
          begin
            if (pwdata[`MMLS_ST_ILLEGAL])
            begin
              ill_r  <= 1'b0;
              halt_r <= 1'b0;
            end
          end
          default:           fbr_r <= fbr_r;
        endcase
      end
      // Only the script register path loads first_byte_received.
      if (fbr_load)
        fbr_r <= fbr_data;
      // Later assignments below win, so a new illegal event beats a same-cycle clear.
      case (state_r)
        S_IDLE:
        begin
          ready_r <= ~halt_r & ~accept;
          if (accept)
          begin
            w0_r      <= instr_w0;
            operand_r <= instr_w1;
            csave_r   <= instr_w2;
            state_r   <= S_DEC;
          end
        end
        S_DEC:
        begin
          state_r <= S_DONE;
          case (op)
            `MMLS_OP_TC:
            begin
              if (tc_take)
              begin
                jump_r  <= 1'b1;
                jaddr_r <= operand_r;
                iptr_r  <= operand_r + `MMLS_JUMP_STEP;
              end
            end
            `MMLS_OP_MOVE:
            begin
              bcount_r <= w0_r[23:0];
              rleft_r  <= w0_r[23:0];
              rptr_r   <= 2'h0;
              wptr_r   <= 2'h0;
              fcnt_r   <= 3'h0;
              if (w0_r[28:25] != 4'h0)
              begin
                ill_r   <= 1'b1;
                cause_r <= `MMLS_CAUSE_RSVD;
                halt_r  <= 1'b1;
                state_r <= S_IDLE;
              end
              else if (operand_r[1:0] != csave_r[1:0])
              begin
                ill_r   <= 1'b1;
                cause_r <= `MMLS_CAUSE_ALIGN;
                halt_r  <= 1'b1;
                state_r <= S_IDLE;
              end
              else
              begin
                flush_r <= ~(w0_r[`MMLS_W0_MOVE_NOFL] & pf_en);
                if (w0_r[23:0] != 24'h000000)
                  state_r <= S_MRD;
              end
            end
            `MMLS_OP_LS:
            begin
              if (ls_bad)
              begin
                ill_r   <= 1'b1;
                cause_r <= `MMLS_CAUSE_COUNT;
                halt_r  <= 1'b1;
                state_r <= S_IDLE;
              end
              else
              begin
                flush_r    <= ~ls_load & ~(w0_r[`MMLS_W0_LS_NOFL] & pf_en);
                bm_req_r   <= 1'b1;
                bm_we_r    <= ~ls_load;
                bm_io_r    <= ls_load ? dma_mode_register_r[`MMLS_DMA_MODE_REGISTER_SRC_IO] : dma_mode_register_r[`MMLS_DMA_MODE_REGISTER_DST_IO];
                bm_addr_r  <= ls_addr;
                bm_wdata_r <= rd_word(ls_idx);
                // Own-register target: the cycle runs but no lane carries data.
                bm_be_r    <= own_hit(ls_addr) ? 4'h0 : ls_be;
                operand_r  <= ls_addr;
                state_r    <= S_LS;
              end
            end
            default:
            begin
              ill_r   <= 1'b1;
              cause_r <= `MMLS_CAUSE_OPC;
              halt_r  <= 1'b1;
              state_r <= S_IDLE;
            end
          endcase
        end
        S_LS:
        begin
          if (bm_ack)
          begin
            bm_req_r <= 1'b0;
            if (own_hit(operand_r))
            begin
              ill_r   <= 1'b1;
              cause_r <= `MMLS_CAUSE_SELF;
              halt_r  <= 1'b1;
              state_r <= S_IDLE;
            end
            else
            begin
              if (ls_load)
                wr_word(ls_idx, bm_rdata, bm_be_r);
              state_r <= S_DONE;
            end
          end
        end
        S_MRD:
        begin
          // Own-window sources are read internally, without a bus cycle.
          if (own_hit(operand_r) || (bm_req_r && bm_ack))
          begin
            bm_req_r         <= 1'b0;
            fifo_d_r[wptr_r] <= own_hit(operand_r) ? rd_word(operand_r[6:2]) : bm_rdata;
            fifo_b_r[wptr_r] <= rbe;
            wptr_r           <= wptr_r + 2'h1;
            fcnt_r           <= fcnt_r + 3'h1;
            rleft_r          <= rleft_r - {21'h000000, rn};
            operand_r        <= {operand_r[31:2] + 30'h00000001, 2'h0};
            if ((fcnt_r + 3'h1 == `MMLS_FIFO_DEPTH) || (rleft_r == {21'h000000, rn}))
              state_r <= S_MWR;
          end
          else if (!bm_req_r)
          begin
            bm_req_r  <= 1'b1;
            bm_we_r   <= 1'b0;
            bm_io_r   <= dma_mode_register_r[`MMLS_DMA_MODE_REGISTER_SRC_IO];
            bm_addr_r <= {operand_r[31:2], 2'h0};
            bm_be_r   <= rbe;
          end
        end
        S_MWR:
        begin
          if (own_hit(csave_r) || (bm_req_r && bm_ack))
          begin
            bm_req_r <= 1'b0;
            if (own_hit(csave_r))
              wr_word(csave_r[6:2], fifo_d_r[rptr_r], fifo_b_r[rptr_r]);
            rptr_r   <= rptr_r + 2'h1;
            fcnt_r   <= fcnt_r - 3'h1;
            bcount_r <= bcount_r - {21'h000000, pop4(fifo_b_r[rptr_r])};
            csave_r  <= {csave_r[31:2] + 30'h00000001, 2'h0};
            if (fcnt_r == 3'h1)
              state_r <= (bcount_r == {21'h000000, pop4(fifo_b_r[rptr_r])}) ? S_DONE : S_MRD;
          end
          else if (!bm_req_r)
          begin
            bm_req_r   <= 1'b1;
            bm_we_r    <= 1'b1;
            bm_io_r    <= dma_mode_register_r[`MMLS_DMA_MODE_REGISTER_DST_IO];
            bm_addr_r  <= {csave_r[31:2], 2'h0};
            bm_wdata_r <= fifo_d_r[rptr_r];
            bm_be_r    <= fifo_b_r[rptr_r];
          end
        end
        S_DONE:
        begin
          // data_structure_base is never a move scratch here, so it survives.
          done_r  <= 1'b1;
          ready_r <= ~halt_r;
          state_r <= S_IDLE;
        end
        default:
        begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

endmodule

// [mmls_exec_properties.sv]
// Port-level assertions for the memory move and load/store execution unit.
`timescale 1ns/1ps
`include "mmls_defines.vh"
module mmls_exec_chk (
  // Clock and reset
  input wire        sys_clk,
  input wire        rst,
  // Instruction side
  input wire        instr_valid,
  input wire        instr_ready,
  input wire [31:0] instr_w0,
  input wire [31:0] instr_w1,
  input wire [31:0] instr_w2,
  input wire        fbr_load,
  input wire [7:0]  fbr_data,
  // Bus master and events
  input wire        bm_req,
  input wire        bm_we,
  input wire [31:0] bm_addr,
  input wire [3:0]  bm_be,
  input wire        bm_ack,
  input wire        exec_done,
  input wire        jump_taken,
  input wire [31:0] jump_addr,
  input wire        illegal_instr
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Shadow of the compare byte; only the script load path may change it.
  reg  [7:0] fbr_r;
  wire       acc = instr_valid && instr_ready;
  wire [2:0] op  = instr_w0[31:29];
  wire       hit = ((fbr_r ^ instr_w0[7:0]) & ~instr_w0[15:8]) == 8'h00;
  wire       go  = !instr_w0[18] || (hit == instr_w0[19]);
  wire [3:0] top = {1'b0, instr_w0[2:0]} + {2'h0, instr_w1[1:0]};
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      fbr_r <= 8'h00;
    else if (fbr_load)
      fbr_r <= fbr_data;
  end
  sequence s_tc;
    acc && op == `MMLS_OP_TC;
  endsequence
  sequence s_mv;
    acc && op == `MMLS_OP_MOVE;
  endsequence
  sequence s_ill;
    ##2 illegal_instr;
  endsequence
  jump_target_a: assert property (s_tc ##0 go |-> ##2 jump_taken && jump_addr == $past(instr_w1, 2))
    else $error("taken jump missing or wrong target");
  jump_skip_a: assert property (s_tc ##0 !go |-> ##2 !jump_taken ##1 exec_done)
    else $error("jump taken on failed compare");
  move_align_a: assert property (s_mv ##0 instr_w1[1:0] != instr_w2[1:0] |-> s_ill)
    else $error("misaligned move not flagged");
  move_rsvd_a: assert property (s_mv ##0 instr_w0[28:25] != 4'h0 |-> s_ill)
    else $error("reserved move bits not flagged");
  ls_count_a: assert property (acc && op == `MMLS_OP_LS && !instr_w0[28] &&
    (instr_w0[2:0] == 3'h0 || top > 4'h4) |-> s_ill)
    else $error("bad load/store count not flagged");
  bad_op_a: assert property (acc && op != `MMLS_OP_TC && op != `MMLS_OP_MOVE && op != `MMLS_OP_LS |-> s_ill)
    else $error("unknown opcode not flagged");
  halt_hold_a: assert property (illegal_instr |-> !instr_ready && !exec_done)
    else $error("execution continued after illegal instruction");
  bus_hold_a: assert property (bm_req && !bm_ack |=> bm_req && $stable(bm_addr) && $stable(bm_be) && $stable(bm_we))
    else $error("bus request changed before acknowledge");
endmodule

bind mmls_exec mmls_exec_chk mmls_exec_chk_inst (
  .sys_clk(sys_clk), .rst(rst), .instr_valid(instr_valid), .instr_ready(instr_ready),
  .instr_w0(instr_w0), .instr_w1(instr_w1), .instr_w2(instr_w2), .fbr_load(fbr_load), .fbr_data(fbr_data),
  .bm_req(bm_req), .bm_we(bm_we), .bm_addr(bm_addr), .bm_be(bm_be), .bm_ack(bm_ack), .exec_done(exec_done),
  .jump_taken(jump_taken), .jump_addr(jump_addr), .illegal_instr(illegal_instr)
);

// [mmls_bus.sv]
// Behavioural memory and I/O target on the far side of the bus master.
`timescale 1ns/1ps
module mmls_bus (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        rst,
  // Requests
  input  wire        bm_req,
  input  wire        bm_we,
  input  wire        bm_io,
  input  wire [31:0] bm_addr,
  input  wire [31:0] bm_wdata,
  input  wire [3:0]  bm_be,
  input  wire [3:0]  wait_cyc,
  // Answers
  output reg         bm_ack,
  output reg  [31:0] bm_rdata
);
  reg     [31:0] mem [0:255];
  reg     [31:0] last_addr;
  reg     [3:0]  last_be;
  reg     [3:0]  cnt_r;
  integer        n_io_rd = 0;
  integer        n_io_wr = 0;
  integer        j;
  // Read data flips every idle cycle so a late sample never looks right.
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      bm_ack <= 1'b0;
      cnt_r <= 4'h0;
      bm_rdata <= 32'h0;
    end
    else if (bm_ack || !bm_req)
    begin
      bm_ack <= 1'b0;
      bm_rdata <= ~bm_rdata;
    end
    else if (cnt_r != wait_cyc)
      cnt_r <= cnt_r + 4'h1;
    else
    begin
      cnt_r <= 4'h0;
      bm_ack <= 1'b1;
      last_addr <= bm_addr;
      last_be <= bm_be;
      if (bm_we)
      begin
        for (j = 0; j < 4; j = j + 1)
          if (bm_be[j])
            mem[bm_addr[9:2]][8*j +: 8] <= bm_wdata[8*j +: 8];
        n_io_wr <= n_io_wr + bm_io;
      end
      else
      begin
        bm_rdata <= mem[bm_addr[9:2]];
        n_io_rd <= n_io_rd + bm_io;
      end
    end
  end
endmodule

// [tb_top.sv]
// Self-checking bench for the memory move and load/store execution unit.
`timescale 1ns/1ps
`include "mmls_defines.vh"
module tb_top;
  reg               sys_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg               instr_valid = 1'b0, fbr_load = 1'b0, perr, jt;
  reg        [7:0]  paddr = 8'h00, fbr_data = 8'h00;
  reg        [31:0] pwdata = 32'h0, instr_w0 = 32'h0, instr_w1 = 32'h0, instr_w2 = 32'h0, q, ja;
  reg        [3:0]  wait_cyc = 4'h0;
  reg        [9:0]  row;
  wire       [31:0] prdata, bm_addr, bm_wdata, bm_rdata, jump_addr;
  wire       [3:0]  bm_be;
  wire              pready, pslverr, instr_ready, bm_req, bm_we, bm_io, bm_ack;
  wire              exec_done, jump_taken, prefetch_flush, illegal_instr;
  integer           n_fail = 0, n_checks = 0, n_flush = 0, i, f;
  // Store rows: offset, count, illegal expected, lanes expected.
  localparam [69:0] rows_c = {10'h010, 10'h350, 10'h190, 10'h328, 10'h24c, 10'h16e, 10'h08f};
  mmls_exec mmls_exec_inst (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .instr_valid(instr_valid), .instr_w0(instr_w0), .instr_w1(instr_w1), .instr_w2(instr_w2),
    .instr_ready(instr_ready), .fbr_load(fbr_load), .fbr_data(fbr_data), .bm_req(bm_req), .bm_we(bm_we),
    .bm_io(bm_io), .bm_addr(bm_addr), .bm_wdata(bm_wdata), .bm_be(bm_be), .bm_ack(bm_ack), .bm_rdata(bm_rdata),
    .exec_done(exec_done), .jump_taken(jump_taken), .jump_addr(jump_addr), .prefetch_flush(prefetch_flush),
    .illegal_instr(illegal_instr));
  mmls_bus mmls_bus_inst (.sys_clk(sys_clk), .rst(rst), .bm_req(bm_req), .bm_we(bm_we), .bm_io(bm_io),
    .bm_addr(bm_addr), .bm_wdata(bm_wdata), .bm_be(bm_be), .wait_cyc(wait_cyc), .bm_ack(bm_ack),
    .bm_rdata(bm_rdata));
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
    if (prefetch_flush === 1'b1)
      n_flush = n_flush + 1;
  function [31:0] ls(input ld, input rel, input nf, input [6:0] ra, input [2:0] n);
    ls = {3'h7, rel, 2'h0, nf, ld, 1'h0, ra, 13'h0000, n};
  endfunction
  function [31:0] lm(input [3:0] b);
    lm = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
  begin
    n_checks = n_checks + 1;
    if (got !== exp)
    begin
      n_fail = n_fail + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    integer k;
  begin
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    for (k = 0; k < 99 && pready !== 1'b1; k = k + 1)
      @(posedge sys_clk);
    q = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  end
  endtask
  task wr(input [4:0] x, input [31:0] d);
    apb(1'b1, {1'b0, x, 2'h0}, d);
  endtask
  task rd(input [4:0] x, input [31:0] e);
  begin
    apb(1'b0, {1'b0, x, 2'h0}, 32'h0);
    chk(q, e);
  end
  endtask
  task run(input [31:0] a, input [31:0] b, input [31:0] c);
    integer k;
  begin
    instr_w0 <= a;
    instr_w1 <= b;
    instr_w2 <= c;
    instr_valid <= 1'b1;
    jt = 1'b0;
    @(posedge sys_clk);
    for (k = 0; k < 99 && instr_ready !== 1'b1; k = k + 1)
      @(posedge sys_clk);
    instr_valid <= 1'b0;
    for (k = 0; k < 999 && exec_done !== 1'b1 && illegal_instr !== 1'b1 && !jt; k = k + 1)
    begin
      @(posedge sys_clk);
      jt = jump_taken === 1'b1;
      ja = jump_addr;
    end
    repeat (2) @(posedge sys_clk);
  end
  endtask
  task report_and_stop;
  begin
    if (n_fail == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    n_fail = n_fail + 1;
    report_and_stop;
  end
  initial
  begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    wr(`MMLS_IDX_SCRATCH, 32'h44332211);
    for (i = 0; i < 7; i = i + 1)
    begin
      row = rows_c[i*10 +: 10];
      mmls_bus_inst.mem[8'h40] = 32'h0;
      wait_cyc <= {2'h0, row[9:8]};
      run(ls(1'b0, 1'b0, 1'b0, {5'h07, row[9:8]}, row[7:5]), {30'h00000040, row[9:8]}, 32'h0);
      chk(illegal_instr, row[4]);
      if (row[4])
        wr(`MMLS_IDX_STATUS, 32'h1);
      else
      begin
        chk(mmls_bus_inst.last_be, row[3:0]);
        chk(mmls_bus_inst.mem[8'h40], 32'h44332211 & lm(row[3:0]));
      end
    end
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    rd(`MMLS_IDX_REGBASE, 32'hffffff80);
    apb(1'b0, 8'h2c, 32'h0);
    chk(perr, 1'b1);
    fbr_data <= 8'ha5;
    fbr_load <= 1'b1;
    @(posedge sys_clk);
    fbr_load <= 1'b0;
    wr(`MMLS_IDX_FBR, 32'h3c);
    mmls_bus_inst.mem[8'h80] = 32'h87654321;
    run(ls(1'b1, 1'b0, 1'b0, 7'h0c, 3'h1), 32'h200, 32'h0);
    rd(`MMLS_IDX_FBR, 32'ha5);
    run(ls(1'b0, 1'b0, 1'b0, 7'h0c, 3'h1), 32'h100, 32'h0);
    chk(mmls_bus_inst.mem[8'h40] & 32'hff, 32'ha5);
    wr(`MMLS_IDX_DMA_MODE_REGISTER, 32'h20);
    f = mmls_bus_inst.n_io_rd;
    run(ls(1'b1, 1'b0, 1'b0, 7'h1c, 3'h4), 32'h200, 32'h0);
    chk(mmls_bus_inst.n_io_rd - f, 1);
    rd(`MMLS_IDX_SCRATCH, 32'h87654321);
    wr(`MMLS_IDX_DMA_MODE_REGISTER, 32'h10);
    wr(`MMLS_IDX_DSBASE, 32'hf0);
    run(ls(1'b1, 1'b1, 1'b0, 7'h1c, 3'h4), 32'h00fffff0, 32'h0);
    chk(mmls_bus_inst.last_addr, 32'he0);
    wr(`MMLS_IDX_DCTRL, 32'h2);
    for (i = 0; i < 2; i = i + 1)
    begin
      f = n_flush;
      run(ls(1'b0, 1'b0, i[0], 7'h1c, 3'h4), 32'h100, 32'h0);
      chk(n_flush - f, {31'h0, !i[0]});
    end
    run(ls(1'b0, 1'b0, 1'b0, 7'h1c, 3'h4), 32'hffffff80, 32'h0);
    chk(mmls_bus_inst.last_addr, 32'hffffff80);
    chk({mmls_bus_inst.last_be, 3'h0, illegal_instr}, 8'h01);
    wr(`MMLS_IDX_STATUS, 32'h1);
    mmls_bus_inst.mem[8'hc0] = 32'h11223344;
    mmls_bus_inst.mem[8'hc1] = 32'h55667788;
    mmls_bus_inst.mem[8'he0] = 32'h0;
    f = n_flush;
    i = mmls_bus_inst.n_io_wr;
    wait_cyc <= 4'h3;
    run(32'hc0000006, 32'h302, 32'h382);
    chk(mmls_bus_inst.mem[8'he0], 32'h11220000);
    chk(mmls_bus_inst.mem[8'he1], 32'h55667788);
    chk(mmls_bus_inst.n_io_wr - i, 2);
    chk(n_flush - f, 1);
    rd(`MMLS_IDX_DSBASE, 32'hf0);
    run(32'hc0000004, 32'h300, 32'hffffff9c);
    rd(`MMLS_IDX_SCRATCH, 32'h11223344);
    for (i = 0; i < 2; i = i + 1)
    begin
      run(i[0] ? 32'hc2000004 : 32'hc0000004, i[0] ? 32'h300 : 32'h301, 32'h382);
      chk(illegal_instr, 1'b1);
      wr(`MMLS_IDX_STATUS, 32'h1);
    end
    run(32'h800c0fa0, 32'h1000, 32'h0);
    chk({jt, ja}, {1'b1, 32'h1000});
    rd(`MMLS_IDX_IPTR, 32'h1004);
    run(32'h800c00a0, 32'h1000, 32'h0);
    chk(jt, 1'b0);
    run(32'h0, 32'h0, 32'h0);
    rd(`MMLS_IDX_STATUS, 32'h10b);
    wr(`MMLS_IDX_STATUS, 32'h1);
    report_and_stop;
  end
endmodule
